// >>> logic/amc_pkg.sv
// How it works
// - Polarity bit 0 gives offset binary: zeros, top bit only, all ones.
// - Polarity bit 1 gives straight binary: zeros at zero, all ones at full scale.
// - Port output enable set turns on drivers of both shared pins.
// - While enabled, high port bit drives positive pin, low bit the negative pin.
// - A driven level stays until its bit is rewritten or enable cleared.
// - Length bit picks 24 or 16 bit reads; ready returns high after the length.
// - Range field picks 10, 20, 40 or 80 mV span, symmetric or zero based.
// - Clock output disable forces the clock output pin low.
// - With external master clock, disable keeps conversions running.
// - With a crystal, disable stops the clock and all conversions.
package amc_pkg;
	// ----------------------------------------
	// Mode register layout
	// ----------------------------------------
	localparam int MODE_W = 16;
	localparam logic [15:0] MODE_RESET = 16'h0000;
	localparam int POL_BIT = 12;
	localparam int PORT_EN_BIT = 11;
	localparam int PHI_BIT = 10;
	localparam int PLO_BIT = 9;
	localparam int LEN_BIT = 8;
	localparam int REF_BIT = 7;
	localparam int RSV_BIT = 6;
	localparam int RNG_HI = 5;
	localparam int RNG_LO = 4;
	localparam int CKD_BIT = 3;
	// ----------------------------------------
	// Result and read timing
	// ----------------------------------------
	localparam int RES_W = 24;
	localparam logic [4:0] LEN_LONG = 5'h18;
	localparam logic [4:0] LEN_SHORT = 5'h10;
	// ----------------------------------------
	// Nominal spans in mV per range code
	// ----------------------------------------
	localparam logic [6:0] SPAN_00 = 7'h0A;
	localparam logic [6:0] SPAN_01 = 7'h14;
	localparam logic [6:0] SPAN_10 = 7'h28;
	localparam logic [6:0] SPAN_11 = 7'h50;
endpackage

// >>> logic/amc_coder.sv
`timescale 1ns/100ps
// Turns a signed modulator result into the selected output coding
module amc_coder (
	// Raw result and coding choice
	input wire logic [23:0] raw_i,
	input wire logic unipolar_i,
	// Coded result
	output logic [23:0] code_o
);
	// Unipolar doubles positive results below half scale, saturates the rest to all ones and clips negatives to zero
	always_comb begin
		if (unipolar_i) begin
			if (raw_i[23]) begin
				code_o = 24'h000000;
			end else if (raw_i[22]) begin
				code_o = 24'hFFFFFF;
			end else begin
				code_o = {raw_i[22:0], raw_i[22]};
			end
		end else begin
			code_o = {~raw_i[23], raw_i[22:0]};
		end
	end
endmodule

// >>> logic/amc_mode_ctrl.sv
`timescale 1ns/100ps
module amc_mode_ctrl (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Mode register access from the serial front end
	input wire logic mode_wr_i,
	input wire logic [15:0] mode_wdata_i,
	output logic [15:0] mode_rdata_o,
	// Conversion results from the filter
	input wire logic res_valid_i,
	input wire logic [23:0] res_raw_i,
	// Data read pins
	input wire logic sclk_i,
	input wire logic read_n_i,
	output logic sdo_o,
	output logic ready_n_o,
	// Clocking
	input wire logic crystal_i,
	output logic mclk_out_o,
	output logic conv_run_o,
	// Shared analog and port pins
	output logic shared_input_pin_pos_o,
	output logic shared_input_pin_pos_oe_o,
	output logic shared_input_pin_neg_o,
	output logic shared_input_pin_neg_oe_o,
	// Decoded analog settings
	output logic [6:0] span_mv_o,
	output logic reference_scale_select_o
);
	// ----------------------------------------
	// Mode register
	// ----------------------------------------
	logic [15:0] mode_ff, nxt_mode;
	logic polarity, port_output_enable, port_bit_high, port_bit_low;
	logic result_length_select, clock_output_disable;
	logic [1:0] input_range_field;

	// Reserved bit is not stored, so it always reads back zero
	always_comb begin
		nxt_mode = mode_ff;
		if (mode_wr_i) begin
			nxt_mode = mode_wdata_i;
			nxt_mode[amc_pkg::RSV_BIT] = 1'b0;
		end
	end
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_ff <= amc_pkg::MODE_RESET;
		end else begin
			mode_ff <= nxt_mode;
		end
	end
	assign mode_rdata_o = mode_ff;
	assign polarity = mode_ff[amc_pkg::POL_BIT];
	assign port_output_enable = mode_ff[amc_pkg::PORT_EN_BIT];
	assign port_bit_high = mode_ff[amc_pkg::PHI_BIT];
	assign port_bit_low = mode_ff[amc_pkg::PLO_BIT];
	assign result_length_select = mode_ff[amc_pkg::LEN_BIT];
	assign clock_output_disable = mode_ff[amc_pkg::CKD_BIT];
	assign input_range_field = mode_ff[amc_pkg::RNG_HI:amc_pkg::RNG_LO];
	assign reference_scale_select_o = mode_ff[amc_pkg::REF_BIT];

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [2:0] s1_ff, s2_ff, nxt_s1, nxt_s2;
	logic sclk_d_ff, nxt_sclk_d;
	logic sclk_s, read_s, crystal_s, sclk_rise;

	// Two flops per pin; only the second stage feeds logic
	always_comb begin
		nxt_s1 = {crystal_i, read_n_i, sclk_i};
		nxt_s2 = s1_ff;
		nxt_sclk_d = s2_ff[0];
	end
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s1_ff <= 3'h2;
			s2_ff <= 3'h2;
			sclk_d_ff <= 1'b0;
		end else begin
			s1_ff <= nxt_s1;
			s2_ff <= nxt_s2;
			sclk_d_ff <= nxt_sclk_d;
		end
	end
	assign sclk_s = s2_ff[0];
	assign read_s = ~s2_ff[1];
	assign crystal_s = s2_ff[2];
	assign sclk_rise = sclk_s & ~sclk_d_ff & read_s;

	// ----------------------------------------
	// Master clock output and conversion gate
	// ----------------------------------------
	logic mclk_ff, nxt_mclk, run_ff, nxt_run;

	// Output runs at half the core clock; a crystal with clock output disable set stops conversions
	always_comb begin
		nxt_mclk = clock_output_disable ? 1'b0 : ~mclk_ff;
		nxt_run = ~(crystal_s & clock_output_disable);
	end
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mclk_ff <= 1'b0;
			run_ff <= 1'b1;
		end else begin
			mclk_ff <= nxt_mclk;
			run_ff <= nxt_run;
		end
	end
	assign mclk_out_o = mclk_ff;
	assign conv_run_o = run_ff;

	// ----------------------------------------
	// Port pins and range decode
	// ----------------------------------------
	logic pos_ff, pos_oe_ff, neg_ff, neg_oe_ff, nxt_pos, nxt_pos_oe, nxt_neg, nxt_neg_oe;
	logic [6:0] span_ff, nxt_span;

	// Levels follow the stored bits, so they persist between writes
	always_comb begin
		nxt_pos_oe = port_output_enable;
		nxt_neg_oe = port_output_enable;
		nxt_pos = port_output_enable & port_bit_high;
		nxt_neg = port_output_enable & port_bit_low;
		case (input_range_field)
			2'h0: nxt_span = amc_pkg::SPAN_00;
			2'h1: nxt_span = amc_pkg::SPAN_01;
			2'h2: nxt_span = amc_pkg::SPAN_10;
			default: nxt_span = amc_pkg::SPAN_11;
		endcase
	end
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pos_ff <= 1'b0;
			pos_oe_ff <= 1'b0;
			neg_ff <= 1'b0;
			neg_oe_ff <= 1'b0;
			span_ff <= amc_pkg::SPAN_00;
		end else begin
			pos_ff <= nxt_pos;
			pos_oe_ff <= nxt_pos_oe;
			neg_ff <= nxt_neg;
			neg_oe_ff <= nxt_neg_oe;
			span_ff <= nxt_span;
		end
	end
	assign shared_input_pin_pos_o = pos_ff;
	assign shared_input_pin_pos_oe_o = pos_oe_ff;
	assign shared_input_pin_neg_o = neg_ff;
	assign shared_input_pin_neg_oe_o = neg_oe_ff;
	assign span_mv_o = span_ff;

	// ----------------------------------------
	// Result capture and serial read
	// ----------------------------------------
	logic [23:0] coded, res_ff, nxt_res;
	logic [4:0] cnt_ff, nxt_cnt, read_len;
	logic rdy_n_ff, nxt_rdy_n, sdo_ff, nxt_sdo, take;

	amc_coder u_coder (
		.raw_i(res_raw_i),
		.unipolar_i(polarity),
		.code_o(coded)
	);

	assign read_len = result_length_select ? amc_pkg::LEN_LONG : amc_pkg::LEN_SHORT;
	assign take = res_valid_i & run_ff;

	// A fresh result wins over a read ending in the same cycle
	always_comb begin
		nxt_res = res_ff;
		nxt_cnt = cnt_ff;
		nxt_rdy_n = rdy_n_ff;
		nxt_sdo = sdo_ff;
		if (!read_s) begin
			nxt_cnt = 5'h00;
		end
		if (sclk_rise && !rdy_n_ff) begin
			nxt_sdo = res_ff[5'h17 - cnt_ff];
			nxt_cnt = cnt_ff + 5'h01;
			if (cnt_ff == read_len - 5'h01) begin
				nxt_rdy_n = 1'b1;
				nxt_cnt = 5'h00;
			end
		end
		if (take) begin
			nxt_res = coded;
			nxt_rdy_n = 1'b0;
			nxt_cnt = 5'h00;
		end
	end
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			res_ff <= 24'h000000;
			cnt_ff <= 5'h00;
			rdy_n_ff <= 1'b1;
			sdo_ff <= 1'b0;
		end else begin
			res_ff <= nxt_res;
			cnt_ff <= nxt_cnt;
			rdy_n_ff <= nxt_rdy_n;
			sdo_ff <= nxt_sdo;
		end
	end
	assign ready_n_o = rdy_n_ff;
	assign sdo_o = sdo_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_last_short;
		sclk_rise && !rdy_n_ff && !result_length_select && cnt_ff == (amc_pkg::LEN_SHORT - 5'h01) && !take;
	endsequence
	sequence s_mid_long;
		sclk_rise && !rdy_n_ff && result_length_select && cnt_ff == (amc_pkg::LEN_SHORT - 5'h01) && !take;
	endsequence
	property p_bip_zero;
		@(posedge clk_i) disable iff (!rstn_i) take && !polarity && res_raw_i == 24'h000000 |=> res_ff == 24'h800000;
	endproperty
	a_bip_zero: assert property (p_bip_zero) else $error("bipolar zero not top bit only");
	property p_bip_neg;
		@(posedge clk_i) disable iff (!rstn_i) take && !polarity && res_raw_i == 24'h800000 |=> res_ff == 24'h000000;
	endproperty
	a_bip_neg: assert property (p_bip_neg) else $error("bipolar negative full scale not zeros");
	property p_uni_full;
		@(posedge clk_i) disable iff (!rstn_i) take && polarity && res_raw_i == 24'h7FFFFF |=> res_ff == 24'hFFFFFF;
	endproperty
	a_uni_full: assert property (p_uni_full) else $error("unipolar full scale not all ones");
	property p_port_drive;
		@(posedge clk_i) disable iff (!rstn_i) port_output_enable |=> shared_input_pin_pos_oe_o && shared_input_pin_neg_oe_o
			&& shared_input_pin_pos_o == $past(port_bit_high) && shared_input_pin_neg_o == $past(port_bit_low);
	endproperty
	a_port_drive: assert property (p_port_drive) else $error("port pins not driven from port bits");
	property p_port_hold;
		@(posedge clk_i) disable iff (!rstn_i) port_output_enable && !mode_wr_i ##1 port_output_enable
			|=> $stable(shared_input_pin_pos_o) && $stable(shared_input_pin_neg_o);
	endproperty
	a_port_hold: assert property (p_port_hold) else $error("port level changed without a write");
	property p_release;
		@(posedge clk_i) disable iff (!rstn_i) !port_output_enable |=> !shared_input_pin_pos_oe_o && !shared_input_pin_neg_oe_o;
	endproperty
	a_release: assert property (p_release) else $error("port drivers not released");
	property p_clk_low;
		@(posedge clk_i) disable iff (!rstn_i) clock_output_disable [*2] |-> !mclk_out_o;
	endproperty
	a_clk_low: assert property (p_clk_low) else $error("clock output not held low");
	property p_run_gate;
		@(posedge clk_i) disable iff (!rstn_i) 1'b1 |=> conv_run_o == !($past(crystal_s) && $past(clock_output_disable));
	endproperty
	a_run_gate: assert property (p_run_gate) else $error("conversion gate wrong for clock source");
	property p_len16;
		@(posedge clk_i) disable iff (!rstn_i) s_last_short |=> ready_n_o;
	endproperty
	a_len16: assert property (p_len16) else $error("short read did not end after 16 clocks");
	property p_len24;
		@(posedge clk_i) disable iff (!rstn_i) s_mid_long |=> !ready_n_o;
	endproperty
	a_len24: assert property (p_len24) else $error("long read ended after 16 clocks");
	property p_span;
		@(posedge clk_i) disable iff (!rstn_i) input_range_field == 2'h2 |=> span_mv_o == 7'h28;
	endproperty
	a_span: assert property (p_span) else $error("range code 10 not 40 mV");
endmodule

// >>> sim/amc_host.sv
`timescale 1ns/100ps
// Host side of the data read: strobes the serial clock and gathers result bits
module amc_host (
	// Clock
	input wire logic clk_i,
	// Read pins
	input wire logic sdo_i,
	output logic sclk_o,
	output logic read_n_o
);
	// Serial clock stands low and select high between frames
	initial begin
		sclk_o = 1'b0;
		read_n_o = 1'b1;
	end
	// Four clocks a phase, so the pin synchronisers and the data register settle
	task automatic read_word(input int nbits, output logic [23:0] w);
		w = 24'h000000;
		@(negedge clk_i);
		read_n_o = 1'b0;
		repeat (4) @(negedge clk_i);
		for (int i = 0; i < nbits; i++) begin
			sclk_o = 1'b1;
			repeat (4) @(negedge clk_i);
			w = {w[22:0], sdo_i};
			sclk_o = 1'b0;
			repeat (4) @(negedge clk_i);
		end
		read_n_o = 1'b1;
	endtask
endmodule

// >>> sim/adc_mode_control_fields_tb.sv
`timescale 1ns/100ps
module adc_mode_control_fields_tb;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic mode_wr_i = 1'b0;
	logic [15:0] mode_wdata_i = 16'h0000;
	logic res_valid_i = 1'b0;
	logic [23:0] res_raw_i = 24'h000000;
	logic crystal_i = 1'b0;
	logic sclk, read_n, sdo_o, ready_n_o, mclk_out_o, conv_run_o, ref_o, a;
	logic pos_o, pos_oe, neg_o, neg_oe;
	logic [15:0] mode_rdata_o;
	logic [6:0] span_mv_o;
	logic [23:0] w;
	logic [15:0] pat [5] = '{16'h0C00, 16'h0A00, 16'h0E00, 16'h0800, 16'h0600};
	logic [6:0] spn [4] = '{7'h0A, 7'h14, 7'h28, 7'h50};
	logic [15:0] cm [7] = '{16'h0100, 16'h0100, 16'h0100, 16'h1100, 16'h1100, 16'h1100, 16'h1100};
	logic [23:0] cr [7] = '{24'h000000, 24'h800000, 24'h7FFFFF, 24'h000000, 24'h7FFFFF, 24'h800000, 24'h123456};
	logic [23:0] ce [7] = '{24'h800000, 24'h000000, 24'hFFFFFF, 24'h000000, 24'hFFFFFF, 24'h000000, 24'h2468AC};
	int n_fail = 0;
	int checks = 0;
	int cyc = 0;
	// Half period of 25 ns gives the 20 MHz core clock
	always #25 clk_i = ~clk_i;
	amc_mode_ctrl dut (.clk_i(clk_i), .rstn_i(rstn_i), .mode_wr_i(mode_wr_i), .mode_wdata_i(mode_wdata_i),
		.mode_rdata_o(mode_rdata_o), .res_valid_i(res_valid_i), .res_raw_i(res_raw_i), .sclk_i(sclk),
		.read_n_i(read_n), .sdo_o(sdo_o), .ready_n_o(ready_n_o), .crystal_i(crystal_i),
		.mclk_out_o(mclk_out_o), .conv_run_o(conv_run_o), .shared_input_pin_pos_o(pos_o),
		.shared_input_pin_pos_oe_o(pos_oe), .shared_input_pin_neg_o(neg_o),
		.shared_input_pin_neg_oe_o(neg_oe), .span_mv_o(span_mv_o), .reference_scale_select_o(ref_o));
	amc_host host (.clk_i(clk_i), .sdo_i(sdo_o), .sclk_o(sclk), .read_n_o(read_n));
	// ----------------------------------------
	// Access and compare tasks
	// ----------------------------------------
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One-cycle write strobe, then wait until pins have followed
	task automatic wr(input logic [15:0] d);
		@(negedge clk_i);
		mode_wr_i = 1'b1;
		mode_wdata_i = d;
		@(negedge clk_i);
		mode_wr_i = 1'b0;
		repeat (2) @(negedge clk_i);
	endtask
	task automatic res(input logic [23:0] r);
		@(negedge clk_i);
		res_valid_i = 1'b1;
		res_raw_i = r;
		@(negedge clk_i);
		res_valid_i = 1'b0;
		@(negedge clk_i);
	endtask
	task automatic test_done();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Hang guard; a full run needs about two thousand cycles
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			test_done();
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(negedge clk_i);
		rstn_i = 1'b1;
		chk({20'h00000, pos_oe, neg_oe, pos_o, neg_o}, 24'h000000);
		// Every write reads back as written and sets the port pins from bits 11, 10 and 9
		foreach (pat[i]) begin
			wr(pat[i]);
			chk({8'h00, mode_rdata_o}, {8'h00, pat[i]});
			chk({20'h00000, pos_oe, neg_oe, pos_o, neg_o}, {20'h00000, pat[i][11], pat[i][11],
				pat[i][11] & pat[i][10], pat[i][11] & pat[i][9]});
		end
		// Code 11 is the widest span
		for (int r = 0; r < 4; r++) begin
			wr({8'h00, r == 1, 1'b0, 2'(r), 4'h0});
			chk({17'h00000, span_mv_o}, {17'h00000, spn[r]});
			chk({23'h000000, ref_o}, {23'h000000, r == 1});
		end
		a = mclk_out_o;
		@(negedge clk_i);
		chk({23'h000000, mclk_out_o}, {23'h000000, ~a});
		wr(16'h0008);
		repeat (4) begin
			@(negedge clk_i);
			chk({23'h000000, mclk_out_o}, 24'h000000);
		end
		// External clock: results still arrive and a short read empties them
		res(24'h000000);
		chk({22'h000000, conv_run_o, ready_n_o}, 24'h000002);
		host.read_word(16, w);
		chk(w, 24'h008000);
		chk({23'h000000, ready_n_o}, 24'h000001);
		// Crystal source: conversions stop, a result is dropped
		crystal_i = 1'b1;
		repeat (4) @(negedge clk_i);
		res(24'h7FFFFF);
		chk({22'h000000, conv_run_o, ready_n_o}, 24'h000001);
		crystal_i = 1'b0;
		repeat (4) @(negedge clk_i);
		// Coding in both polarities with 24-bit reads
		foreach (cm[i]) begin
			wr(cm[i]);
			res(cr[i]);
			chk({23'h000000, ready_n_o}, 24'h000000);
			if (i == 0) begin
				host.read_word(16, w);
				chk({23'h000000, ready_n_o}, 24'h000000);
			end
			host.read_word(24, w);
			chk(w, ce[i]);
			chk({23'h000000, ready_n_o}, 24'h000001);
		end
		// Reset in mid-run drops the port drive and a pending result
		wr(16'h0E00);
		res(24'h000000);
		chk({22'h000000, conv_run_o, ready_n_o}, 24'h000002);
		rstn_i = 1'b0;
		@(negedge clk_i);
		chk({8'h00, mode_rdata_o}, {8'h00, amc_pkg::MODE_RESET});
		chk({22'h000000, conv_run_o, ready_n_o}, 24'h000003);
		chk({20'h00000, pos_oe, neg_oe, pos_o, neg_o}, 24'h000000);
		rstn_i = 1'b1;
		repeat (2) @(negedge clk_i);
		chk({20'h00000, pos_oe, neg_oe, pos_o, neg_o}, 24'h000000);
		test_done();
	end
endmodule
